// *** core/idsc_cfg.svh ***
// Purpose: offsets, field positions, reset values of the idle block
// Assumes: register index times four is the APB byte address
// Notes:   included by the package only
`ifndef IDSC_CFG_SVH
`define IDSC_CFG_SVH

// -----------------------------------------------------------------
// Register indices
// -----------------------------------------------------------------
`define IDSC_AW        18
`define IDSC_PCTL_IDX  16'h9400
`define IDSC_PIST_IDX  16'h9401
`define IDSC_MCTL_IDX  16'h9402
`define IDSC_MIST_IDX  16'h9403
`define IDSC_IREQ_IDX  16'h9404

// -----------------------------------------------------------------
// Fields
// -----------------------------------------------------------------
`define IDSC_NPER       14
`define IDSC_HOST_BIT   1
`define IDSC_DMA_BIT    0
`define IDSC_PERI_BIT   3
`define IDSC_MAST_BIT   2

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define IDSC_PCTL_RST  14'h0000
`define IDSC_PIST_RST  14'h0000
`define IDSC_PREQ_RST  14'h0000
`define IDSC_MCTL_RST  2'h0
`define IDSC_MIST_RST  2'h0
`define IDSC_FLAG_RST  1'h0

`endif

// *** core/idsc_pkg.sv ***
// Purpose: shared types of the idle block
// Assumes: constants come from the config header
// Notes:   one bit per unit in each direction
`include "idsc_cfg.svh"

package idsc_pkg;

  typedef logic [`IDSC_NPER-1:0] idsc_per_t;

  // Request or acknowledge, one bit per unit
  typedef struct packed {
    idsc_per_t per;
    logic      host;
    logic      dma;
  } idsc_unit_t;

endpackage : idsc_pkg

// *** core/idsc_top.sv ***
// Purpose: idle status and master idle control, APB slave
// Assumes: units answer idle requests on mclk with a level ack
// Notes:   zero wait state; unmapped addresses answer pslverr
//
// Contract
// (R1) Peripheral status register, read only, resets to zero.
// (R2) Bit 13 shows miscellaneous group idle.
// (R3) Bit 12 shows external memory interface idle.
// (R4) Bit 11 shows tick timer idle.
// (R5) Bit 10 shows watchdog idle.
// (R6) Bit 9 shows parallel pin logic idle.
// (R7) Bit 8 shows async serial port idle.
// (R8) Bits 7..5 show I2C, identification unit, byte port idle.
// (R9) Bits 4..2 show serial ports two, one, zero idle.
// (R10) Bits 1..0 show timers one and zero idle.
// (R11) Master control: bits 1..0 writable, reset zero, rest read zero.
// (R12) Host port stops when master flag rises with bit 1 set.
// (R13) DMA stops when master flag rises with bit 0 set.
// (R14) Master status register read only, upper bits zero, reset zero.
// (R15) Master status bit 1 shows host port idle.
// (R16) Master status bit 0 shows DMA idle.
// (R17) Idle instruction with peripheral flag stops units whose control bit set.
// (R18) Idle instruction with peripheral flag clear wakes every unit.
// (R19) Idle instruction with peripheral flag set wakes units with bit clear.
// (R20) Status bits follow unit acknowledge, not the request.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps

module idsc_top
  import idsc_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [`IDSC_AW-1:0]  paddr,
  input  wire logic [31:0]          pwdata,
  output      logic [31:0]          prdata,
  output      logic                 pready,
  output      logic                 pslverr,
  input  wire logic                 idle_exec,
  input  wire idsc_unit_t           unit_ack,
  output      idsc_unit_t           unit_req
);

  // -----------------------------------------------------------------
  // Decode
  // -----------------------------------------------------------------

  function automatic logic hit(
    input logic [`IDSC_AW-1:0] a,
    input logic [15:0]         idx
  );
    hit = (a[`IDSC_AW-1:2] == idx) && (a[1:0] == 2'h0);
  endfunction : hit

  function automatic logic mapped(input logic [`IDSC_AW-1:0] a);
    mapped = hit(a, `IDSC_PCTL_IDX) || hit(a, `IDSC_PIST_IDX)
          || hit(a, `IDSC_MCTL_IDX) || hit(a, `IDSC_MIST_IDX)
          || hit(a, `IDSC_IREQ_IDX);
  endfunction : mapped

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------

  idsc_per_t    pctl_q;
  idsc_per_t    pist_q;
  logic [1:0]   mctl_q;
  logic [1:0]   mist_q;
  logic         pflag_q;
  logic         mflag_q;
  logic         mflag_dly_q;
  idsc_per_t    preq_q;
  logic         host_req_q;
  logic         dma_req_q;
  logic [31:0]  rdata_q;
  logic         err_q;
  logic         setup;
  logic         wr_acc;
  logic         mflag_rise;

  assign setup      = psel && !penable;
  assign wr_acc     = psel && penable && pwrite;
  assign mflag_rise = mflag_q && !mflag_dly_q;

  // Zero wait state keeps the core's access path short
  assign pready   = 1'b1;
  assign prdata   = rdata_q;
  assign pslverr  = err_q;

  assign unit_req.per  = preq_q;
  assign unit_req.host = host_req_q;
  assign unit_req.dma  = dma_req_q;

  // -----------------------------------------------------------------
  // Writable registers
  // -----------------------------------------------------------------

  always_ff @(posedge mclk)
  begin
    if (rst)
      pctl_q <= `IDSC_PCTL_RST;
    else if (wr_acc && hit(paddr, `IDSC_PCTL_IDX))
      pctl_q <= pwdata[`IDSC_NPER-1:0];
  end

  // (R11) two writable bits
  always_ff @(posedge mclk)
  begin
    if (rst)
      mctl_q <= `IDSC_MCTL_RST;
    else if (wr_acc && hit(paddr, `IDSC_MCTL_IDX))
      mctl_q <= pwdata[1:0];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pflag_q <= `IDSC_FLAG_RST;
      mflag_q <= `IDSC_FLAG_RST;
    end
    else if (wr_acc && hit(paddr, `IDSC_IREQ_IDX))
    begin
      pflag_q <= pwdata[`IDSC_PERI_BIT];
      mflag_q <= pwdata[`IDSC_MAST_BIT];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      mflag_dly_q <= `IDSC_FLAG_RST;
    else
      mflag_dly_q <= mflag_q;
  end

  // -----------------------------------------------------------------
  // Peripheral idle requests
  // -----------------------------------------------------------------

  // (R17) stop selected units
  // (R18) flag clear wakes all
  // (R19) clear bits wake
  always_ff @(posedge mclk)
  begin
    if (rst)
      preq_q <= `IDSC_PREQ_RST;
    else if (idle_exec)
      preq_q <= pflag_q ? pctl_q : `IDSC_PREQ_RST;
  end

  // -----------------------------------------------------------------
  // Master idle requests
  // -----------------------------------------------------------------

  // (R12) host port on rise
  always_ff @(posedge mclk)
  begin
    if (rst)
      host_req_q <= `IDSC_FLAG_RST;
    else if (!mflag_q)
      host_req_q <= 1'b0;
    else if (mflag_rise)
      host_req_q <= mctl_q[`IDSC_HOST_BIT];
  end

  // (R13) DMA on rise
  always_ff @(posedge mclk)
  begin
    if (rst)
      dma_req_q <= `IDSC_FLAG_RST;
    else if (!mflag_q)
      dma_req_q <= 1'b0;
    else if (mflag_rise)
      dma_req_q <= mctl_q[`IDSC_DMA_BIT];
  end

  // -----------------------------------------------------------------
  // Status capture
  // -----------------------------------------------------------------

  // (R20) track acknowledge only
  // (R2) (R3) (R4) (R5) upper unit bits
  // (R6) (R7) (R8) (R9) (R10) lower unit bits
  // (R1) reset to zero
  for (genvar g = 0; g < `IDSC_NPER; g++)
  begin : g_stat
    always_ff @(posedge mclk)
    begin
      if (rst)
        pist_q[g] <= 1'(`IDSC_PIST_RST >> g);
      else
        pist_q[g] <= unit_ack.per[g];
    end
  end

  // (R15) host port idle
  // (R16) DMA idle
  always_ff @(posedge mclk)
  begin
    if (rst)
      mist_q <= `IDSC_MIST_RST;
    else
      mist_q <= {unit_ack.host, unit_ack.dma};
  end

  // -----------------------------------------------------------------
  // Read path
  // -----------------------------------------------------------------

  // (R14) upper bits read zero
  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata_q <= 32'h0000_0000;
    else if (setup)
    begin
      if (hit(paddr, `IDSC_PCTL_IDX))
        rdata_q <= {18'h00000, pctl_q};
      else if (hit(paddr, `IDSC_PIST_IDX))
        rdata_q <= {18'h00000, pist_q};
      else if (hit(paddr, `IDSC_MCTL_IDX))
        rdata_q <= {30'h00000000, mctl_q};
      else if (hit(paddr, `IDSC_MIST_IDX))
        rdata_q <= {30'h00000000, mist_q};
      else if (hit(paddr, `IDSC_IREQ_IDX))
        rdata_q <= {28'h0000000, pflag_q, mflag_q, 2'h0};
      else
        rdata_q <= 32'h0000_0000;
    end
  end

  // Writes to read-only words are dropped quietly
  always_ff @(posedge mclk)
  begin
    if (rst)
      err_q <= 1'b0;
    else if (setup)
      err_q <= !mapped(paddr);
    else if (!psel)
      err_q <= 1'b0;
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_rd(logic [15:0] idx);
    psel && !penable && !pwrite && hit(paddr, idx) ##1 psel && penable;
  endsequence

  sequence s_wr(logic [15:0] idx);
    psel && penable && pwrite && hit(paddr, idx);
  endsequence

  property p_pist_rd;
    s_rd(`IDSC_PIST_IDX) |-> prdata == {18'h00000, $past(unit_ack.per, 2)};
  endproperty
  a_pist_rd: assert property (p_pist_rd) // (R1)
    else $error("peripheral status read mismatch");

  // Write, one idle cycle, then read back: the usual core access pattern
  property p_mctl_wr;
    s_wr(`IDSC_MCTL_IDX) ##1 !psel ##1 s_rd(`IDSC_MCTL_IDX)
      |-> prdata == {30'h00000000, $past(pwdata[1:0], 3)};
  endproperty
  a_mctl_wr: assert property (p_mctl_wr) // (R11)
    else $error("master control readback wrong");

  property p_host_stop;
    mflag_rise && mctl_q[`IDSC_HOST_BIT] |=> unit_req.host;
  endproperty
  a_host_stop: assert property (p_host_stop) // (R12)
    else $error("host port not stopped");

  property p_host_keep;
    mflag_rise && !mctl_q[`IDSC_HOST_BIT] && !unit_req.host |=> !unit_req.host;
  endproperty
  a_host_keep: assert property (p_host_keep) // (R12)
    else $error("host port stopped unasked");

  property p_dma_stop;
    mflag_rise |=> unit_req.dma == $past(mctl_q[`IDSC_DMA_BIT]);
  endproperty
  a_dma_stop: assert property (p_dma_stop) // (R13)
    else $error("DMA request wrong");

  property p_mist_rd;
    s_rd(`IDSC_MIST_IDX)
      |-> prdata == {30'h00000000, $past(unit_ack.host, 2), $past(unit_ack.dma, 2)};
  endproperty
  a_mist_rd: assert property (p_mist_rd) // (R14)
    else $error("master status read mismatch");

  property p_exec_stop;
    idle_exec && pflag_q |=> unit_req.per == $past(pctl_q);
  endproperty
  a_exec_stop: assert property (p_exec_stop) // (R17)
    else $error("idle selection not applied");

  property p_exec_wake;
    idle_exec && !pflag_q |=> unit_req.per == '0;
  endproperty
  a_exec_wake: assert property (p_exec_wake) // (R18)
    else $error("units not woken");

  property p_clear_wake;
    idle_exec && pflag_q |=> (unit_req.per & ~$past(pctl_q)) == '0;
  endproperty
  a_clear_wake: assert property (p_clear_wake) // (R19)
    else $error("deselected unit kept idle");

  property p_ack_only;
    $stable(unit_ack.per) |=> $stable(pist_q);
  endproperty
  a_ack_only: assert property (p_ack_only) // (R20)
    else $error("status moved without acknowledge");

  property p_unmapped;
    setup && !mapped(paddr) ##1 penable |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

endmodule : idsc_top

// *** tb/idsc_unit_model.sv ***
// Purpose: unit side model, acknowledges idle requests
// Assumes: level request in, level idle ack out
// Notes:   slow mode lags four cycles so early status reads show
`timescale 1ns/1ps

module idsc_unit_model
  import idsc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire idsc_unit_t req,
  output      idsc_unit_t ack
);
  idsc_unit_t pipe_q [4];

  // ----------------------------------------
  // Lag line
  // ----------------------------------------
  // A unit needs time to stop, so ack trails the request
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 4; i++)
        pipe_q[i] <= '0;
    end
    else
    begin
      pipe_q[0] <= req;
      for (int i = 1; i < 4; i++)
        pipe_q[i] <= pipe_q[i-1];
    end
  end

  assign ack = slow ? pipe_q[3] : pipe_q[0];
endmodule : idsc_unit_model

// *** tb/tb_idle_domain_status_control.sv ***
// Purpose: self-checking bench of the idle block
// Assumes: zero wait APB slave, units modelled by idsc_unit_model
// Notes:   expectations come from integer model state only
`timescale 1ns/1ps

`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      $display("BAD %s exp %h seen %h", nm, e, g); \
      fail_count++; \
    end \
  end

module tb_idle_domain_status_control
  import idsc_pkg::*;
;
  localparam logic [15:0] IX_PCTL = 16'h9400;
  localparam logic [15:0] IX_PST  = 16'h9401;
  localparam logic [15:0] IX_MCTL = 16'h9402;
  localparam logic [15:0] IX_MST  = 16'h9403;
  localparam logic [15:0] IX_REQ  = 16'h9404;
  localparam logic [15:0] IX_BAD  = 16'h9405;

  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, idle_exec, slow, er;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, v;
  idsc_unit_t  unit_ack, unit_req;
  int          fail_count, samples_checked, pctl_m, exp_per, flag;
  // Expected status history, newest last
  int          hist_q[$];

  idsc_top uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .idle_exec(idle_exec),
    .unit_ack(unit_ack), .unit_req(unit_req));
  idsc_unit_model units (.mclk(mclk), .rst(rst), .slow(slow), .req(unit_req),
    .ack(unit_ack));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial
  begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic apb(input logic w, input logic [15:0] ix, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {ix, 2'b00};
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      fail_count++;
      end_of_test();
    end
  endtask : apb

  task automatic pulse();
    @(posedge mclk);
    idle_exec <= 1'b1;
    @(posedge mclk);
    idle_exec <= 1'b0;
    @(posedge mclk);
    #1;
  endtask : pulse

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    fail_count = 0;
    samples_checked = 0;
    seed = 32'd13;
    {psel, penable, pwrite, idle_exec, slow, rst} = 6'b000001;
    paddr = '0;
    pwdata = '0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    apb(0, IX_PST, 0);
    `CHK("pist_reset", 32'h0, rd)
    apb(0, IX_MCTL, 0);
    `CHK("mctl_reset", 32'h0, rd)
    apb(0, IX_MST, 0);
    `CHK("mst_reset", 32'h0, rd)
    apb(0, IX_BAD, 0);
    `CHK("unmapped_err", 1'b1, er)
    `CHK("unmapped_rd", 32'h0, rd)
    `CHK("pready", 1'b1, pready)
    $display("test reset done");
    // Every master control code, upper bits random
    for (int k = 0; k < 4; k++)
    begin
      v = xs();
      apb(1, IX_MCTL, {v[31:2], k[1:0]});
      apb(0, IX_MCTL, 0);
      `CHK("mctl_rw", k, rd)
      apb(1, IX_REQ, 32'h4);
      repeat (3) @(posedge mclk);
      #1;
      `CHK("host_req", k[1], unit_req.host)
      `CHK("dma_req", k[0], unit_req.dma)
      repeat (8) @(posedge mclk);
      apb(0, IX_MST, 0);
      `CHK("mst_idle", k, rd)
      apb(1, IX_REQ, 32'h0);
      repeat (8) @(posedge mclk);
      apb(0, IX_MST, 0);
      `CHK("mst_wake", 32'h0, rd)
    end
    $display("test master done");
    hist_q.push_back(0);
    for (int k = 0; k < 6; k++)
    begin
      slow <= k[0];
      flag = (k % 3 != 2);
      pctl_m = xs() & 32'h3FFF;
      apb(1, IX_PCTL, pctl_m);
      apb(0, IX_PCTL, 0);
      `CHK("pctl_rb", pctl_m, rd)
      apb(1, IX_REQ, flag << 3);
      apb(0, IX_REQ, 0);
      `CHK("req_rb", flag << 3, rd)
      pulse();
      exp_per = flag ? pctl_m : 0;
      `CHK("per_req", exp_per, unit_req.per)
      apb(0, IX_PST, 0);
      if (slow)
        `CHK("pist_early", hist_q[$], rd)
      repeat (8) @(posedge mclk);
      apb(1, IX_PST, 32'hFFFF);
      `CHK("pist_wr_err", 1'b0, er)
      apb(0, IX_PST, 0);
      `CHK("pist_status", exp_per, rd)
      hist_q.push_back(exp_per);
    end
    $display("test peripheral done");
    end_of_test();
  end
endmodule : tb_idle_domain_status_control
